// >>> bench/tcr_host_model.sv
// host model issuing byte reads of the result register
`default_nettype none
module tcr_host_model (
	input wire logic link_clk, // link clock
	input wire logic [7:0] rd_data, // byte
	input wire logic rd_valid, // strobe
	output logic rd_req, // request
	output logic rd_byte_low // byte select
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rd_req = 1'b0;
		rd_byte_low = 1'b1;
	end
	// select flips once released, a missing strobe yields unknowns
	task automatic rd(input logic lo, output logic [7:0] d);
		@(posedge link_clk);
		rd_req <= 1'b1;
		rd_byte_low <= lo;
		@(posedge link_clk);
		rd_req <= 1'b0;
		rd_byte_low <= ~lo;
		@(posedge link_clk);
		d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
	endtask
endmodule
`default_nettype wire

// >>> bench/tcr_readout_properties.sv
// checker of the readout sequencer and link read port
`default_nettype none
module tcr_readout_properties
	import tcr_pkg::*;
#(parameter int unsigned CONV_CYCLES = 20) (
	input wire logic ref_clk, // clock
	input wire logic reset, // reset
	input wire logic clk_en, // clock enable
	input wire logic adc_enable, // converting
	input wire logic shutdown_active, // shut down
	input wire tcr_cfg_s cfg, // config
	input wire logic link_clk, // link clock
	input wire logic link_reset, // link reset
	input wire logic rd_req, // read
	input wire logic rd_byte_low, // byte select
	input wire logic [7:0] rd_data, // read byte
	input wire logic rd_valid // read strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] run, next_run;
	logic armed, next_armed;
	always_comb begin
		// frozen edges do not advance the conversion, so they are not counted
		next_run = adc_enable ? (clk_en ? run + 16'h0001 : run) : 16'h0000;
		next_armed = armed | (!adc_enable && run != 16'h0000);
	end
	// first conversion after reset is skipped, its start edge is not fixed
	always_ff @(posedge ref_clk) begin
		run <= reset ? 16'h0000 : next_run;
		armed <= reset ? 1'b0 : next_armed;
	end
	sequence s_wake;
		##[1:4] adc_enable;
	endsequence
	sequence s_asleep;
		##[1:25] shutdown_active;
	endsequence
	conv_len_a: assert property (@(posedge ref_clk) disable iff (reset)
		armed && !adc_enable && run != 16'h0000 |-> run == CONV_CYCLES) else $error("conversion length");
	shut_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
		shutdown_active |-> !adc_enable) else $error("converting in shutdown");
	shut_stay_a: assert property (@(posedge ref_clk) disable iff (reset)
		shutdown_active && cfg.power_down_request |=> shutdown_active) else $error("left shutdown");
	shut_enter_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(cfg.power_down_request) |-> s_asleep) else $error("no shutdown");
	wake_up_a: assert property (@(posedge ref_clk) disable iff (reset)
		shutdown_active && $fell(cfg.power_down_request) |-> s_wake) else $error("no wake");
	rd_answer_a: assert property (@(posedge link_clk) disable iff (link_reset)
		rd_req |=> rd_valid) else $error("read unanswered");
	rd_idle_a: assert property (@(posedge link_clk) disable iff (link_reset)
		!rd_req |=> !rd_valid) else $error("stray strobe");
	rd_hold_a: assert property (@(posedge link_clk) disable iff (link_reset)
		!rd_req |=> $stable(rd_data)) else $error("read byte moved");
	low_zero_a: assert property (@(posedge link_clk) disable iff (link_reset)
		rd_req && rd_byte_low |=> rd_data[2:0] == 3'h0) else $error("unused bits set");
endmodule
bind tcr_readout tcr_readout_properties #(.CONV_CYCLES(CONV_CYCLES)) u_tcr_readout_properties (
	.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .adc_enable(adc_enable), .shutdown_active(shutdown_active),
	.cfg(cfg), .link_clk(link_clk), .link_reset(link_reset), .rd_req(rd_req),
	.rd_byte_low(rd_byte_low), .rd_data(rd_data), .rd_valid(rd_valid));
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of the temperature conversion readout
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module testbench
	import tcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PER [4] = '{400, 200, 80, 40};
	logic ref_clk, reset, clk_en, link_clk, link_reset, rd_req, rd_byte_low, rd_valid, adc_enable, shutdown_active;
	logic [7:0] rd_data;
	logic [15:0] r, w, exp_word;
	tcr_code_t adc_code;
	tcr_cfg_s cfg;
	int fails, samples_checked, code, n, a, b;
	tcr_readout #(.CONV_CYCLES(20), .PERIOD_CYCLES_0(PER[0]), .PERIOD_CYCLES_1(PER[1]), .PERIOD_CYCLES_2(PER[2]),
		.PERIOD_CYCLES_3(PER[3])) u_tcr_readout (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.adc_code(adc_code), .adc_enable(adc_enable), .shutdown_active(shutdown_active), .link_clk(link_clk),
		.link_reset(link_reset), .cfg(cfg), .rd_req(rd_req), .rd_byte_low(rd_byte_low), .rd_data(rd_data),
		.rd_valid(rd_valid));
	tcr_host_model u_tcr_host_model (.link_clk(link_clk), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_req(rd_req), .rd_byte_low(rd_byte_low));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] fmt(input int c, input logic e);
		int lim;
		lim = e ? 4095 : 2047;
		if (c > lim) c = lim;
		if (c < -lim - 1) c = -lim - 1;
		return e ? 16'(c << 3) : 16'(c << 4);
	endfunction
	task automatic end_of_test();
		if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic waitv(input logic sd, input logic v, output int k);
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while ((sd ? shutdown_active : adc_enable) !== v && k < 1000);
		if (k >= 1000) begin
			fails++;
			end_of_test();
		end
	endtask
	// high byte first, low byte only when asked for
	task automatic rd_word(input logic both, output logic [15:0] v);
		u_tcr_host_model.rd(1'b0, v[15:8]);
		v[7:0] = 8'h00;
		if (both) u_tcr_host_model.rd(1'b1, v[7:0]);
	endtask
	initial begin
		reset = 1'b1;
		link_reset = 1'b1;
		adc_code = '0;
		cfg = 4'h8;
		clk_en = 1'b1;
		r = 16'h0052;
		fails = 0;
		samples_checked = 0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		link_reset <= 1'b0;
		rd_word(1'b1, w);
		`CHK("reset word", 16'h0000, w)
		for (int i = 0; i < 12; i++) begin
			waitv(1'b0, 1'b1, n);
			r = lfsr(r);
			code = $signed(r) >>> r[2:0];
			adc_code <= tcr_code_t'(code);
			cfg.extended_range_enable <= i[1];
			waitv(1'b0, 1'b0, n);
			exp_word = fmt(code, i[1]);
			repeat (3) @(posedge ref_clk);
			rd_word(i[0], w);
			`CHK("result", (i[0] ? exp_word : {exp_word[15:8], 8'h00}), w)
		end
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			cfg.rate_select_hi <= i[1];
			cfg.rate_select_lo <= i[0];
			waitv(1'b0, 1'b0, n);
			waitv(1'b0, 1'b1, n);
			waitv(1'b0, 1'b0, a);
			waitv(1'b0, 1'b1, b);
			`CHK("period", PER[i], a + b)
		end
		// ten frozen edges right after a start: the conversion still needs its full 20 running edges
		clk_en <= 1'b0;
		repeat (10) @(posedge ref_clk);
		clk_en <= 1'b1;
		waitv(1'b0, 1'b0, a);
		`CHK("frozen conversion", 20, a)
		waitv(1'b0, 1'b1, n);
		r = lfsr(r);
		code = $signed(r) >>> 5;
		adc_code <= tcr_code_t'(code);
		cfg.power_down_request <= 1'b1;
		exp_word = fmt(code, 1'b1);
		waitv(1'b1, 1'b1, n);
		a = 0;
		repeat (300) begin
			@(posedge ref_clk);
			if (adc_enable !== 1'b0) a++;
		end
		`CHK("idle converter", 0, a)
		rd_word(1'b1, w);
		`CHK("last result", exp_word, w)
		@(posedge ref_clk);
		cfg.power_down_request <= 1'b0;
		waitv(1'b0, 1'b1, n);
		`CHK("wake delay", 1'b1, n <= 5)
		end_of_test();
	end
endmodule
`default_nettype wire

// >>> pkg/tcr_consts.svh
// constants of the temperature conversion readout block
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH

// reference clock and conversion timing
`define TCR_REF_CLK_HZ 10000000
`define TCR_CONV_TIME_MS 26
`define TCR_CONV_CYCLES ((`TCR_REF_CLK_HZ / 1000) * `TCR_CONV_TIME_MS)

// conversion periods for rate codes 00, 01, 10, 11 (0.25 Hz, 1 Hz, 4 Hz, 8 Hz)
`define TCR_PERIOD_MS_0 4000
`define TCR_PERIOD_MS_1 1000
`define TCR_PERIOD_MS_2 250
`define TCR_PERIOD_MS_3 125
`define TCR_PERIOD_CYCLES(ms) ((`TCR_REF_CLK_HZ / 1000) * (ms))

// timer wide enough for the longest period
`define TCR_TIMER_W 26

// rate codes
`define TCR_RATE_025HZ 2'h0
`define TCR_RATE_1HZ 2'h1
`define TCR_RATE_4HZ 2'h2
`define TCR_RATE_8HZ 2'h3
`define TCR_RATE_RESET `TCR_RATE_4HZ

// result register
`define TCR_RESULT_RESET 16'h0000
`define TCR_HI_BYTE 15:8
`define TCR_LO_BYTE 7:0
`define TCR_BYTE_RESET 8'h00

// saturation limits, in 0.0625 degree steps
`define TCR_SAT12_MAX 16'sh07FF
`define TCR_SAT12_MIN 16'shF800
`define TCR_SAT13_MAX 16'sh0FFF
`define TCR_SAT13_MIN 16'shF000

// left-justification shifts
`define TCR_SHIFT12 4
`define TCR_SHIFT13 3

// one-hot sequencer states
`define TCR_ST_CONV 3'h1
`define TCR_ST_WAIT 3'h2
`define TCR_ST_SHUT 3'h4

`endif

// >>> pkg/tcr_pkg.sv
// types of the temperature conversion readout block
`default_nettype none
`include "tcr_consts.svh"

package tcr_pkg;

	// configuration bits as held by the serial interface logic
	typedef struct packed {
		logic rate_select_hi;
		logic rate_select_lo;
		logic extended_range_enable;
		logic power_down_request;
	} tcr_cfg_s;

	typedef enum logic [2:0] {
		TCR_CONV = `TCR_ST_CONV,
		TCR_WAIT = `TCR_ST_WAIT,
		TCR_SHUT = `TCR_ST_SHUT
	} tcr_state_e;

	typedef logic signed [15:0] tcr_code_t;
	typedef logic [15:0] tcr_word_t;

endpackage

`default_nettype wire

// >>> verilog/tcr_format.sv
// result formatter: saturation and left justification of a raw temperature code
`default_nettype none
`include "tcr_consts.svh"

module tcr_format
	import tcr_pkg::*;
(
	input wire tcr_code_t raw_code, // signed code, one step is 0.0625 degree
	input wire logic extended_mode, // 13-bit format when high
	output tcr_word_t result_word // left-justified word, unused bits zero
);

	tcr_code_t sat_code;

	always_comb begin
		if (extended_mode) begin
			if (raw_code > `TCR_SAT13_MAX) begin
				sat_code = `TCR_SAT13_MAX;
			end else if (raw_code < `TCR_SAT13_MIN) begin
				sat_code = `TCR_SAT13_MIN;
			end else begin
				sat_code = raw_code;
			end
			result_word = tcr_word_t'(sat_code <<< `TCR_SHIFT13);
		end else begin
			if (raw_code > `TCR_SAT12_MAX) begin
				sat_code = `TCR_SAT12_MAX;
			end else if (raw_code < `TCR_SAT12_MIN) begin
				sat_code = `TCR_SAT12_MIN;
			end else begin
				sat_code = raw_code;
			end
			result_word = tcr_word_t'(sat_code <<< `TCR_SHIFT12);
		end
	end

endmodule

`default_nettype wire

// >>> verilog/tcr_readout.sv
// conversion sequencer, result register and link-side result readout
`default_nettype none
`include "tcr_consts.svh"

module tcr_readout
	import tcr_pkg::*;
#(
	parameter int unsigned CONV_CYCLES = `TCR_CONV_CYCLES,
	parameter int unsigned PERIOD_CYCLES_0 = `TCR_PERIOD_CYCLES(`TCR_PERIOD_MS_0),
	parameter int unsigned PERIOD_CYCLES_1 = `TCR_PERIOD_CYCLES(`TCR_PERIOD_MS_1),
	parameter int unsigned PERIOD_CYCLES_2 = `TCR_PERIOD_CYCLES(`TCR_PERIOD_MS_2),
	parameter int unsigned PERIOD_CYCLES_3 = `TCR_PERIOD_CYCLES(`TCR_PERIOD_MS_3),
	parameter int unsigned TIMER_W = `TCR_TIMER_W
) (
	input wire logic ref_clk, // sequencer clock, 10 MHz
	input wire logic reset, // synchronous, active high, ref_clk domain
	input wire logic clk_en, // freezes the ref_clk domain while low
	input wire tcr_code_t adc_code, // converter output, asynchronous to ref_clk
	output logic adc_enable, // converter powered and converting
	output logic shutdown_active, // device sits in shutdown
	input wire logic link_clk, // serial interface clock
	input wire logic link_reset, // synchronous, active high, link_clk domain
	input wire tcr_cfg_s cfg, // configuration bits, link_clk domain
	input wire logic rd_req, // read one result byte, link_clk domain
	input wire logic rd_byte_low, // byte select: 0 high byte, 1 low byte
	output logic [7:0] rd_data, // byte returned for the last read
	output logic rd_valid // one link cycle pulse with rd_data
);

	// reset rate code, split below into its two configuration bits
	localparam logic [1:0] RATE_RESET = `TCR_RATE_RESET;

	// configuration crossing into ref_clk
	tcr_cfg_s cfg_meta;
	tcr_cfg_s cfg_sync;
	tcr_cfg_s next_cfg_meta;
	tcr_cfg_s next_cfg_sync;
	tcr_cfg_s cfg_reset_value;

	// converter code crossing into ref_clk
	tcr_code_t code_meta;
	tcr_code_t code_sync;
	tcr_code_t next_code_meta;
	tcr_code_t next_code_sync;
	tcr_code_t code_prev;
	tcr_code_t code_steady;
	tcr_code_t next_code_prev;
	tcr_code_t next_code_steady;

	// sequencer
	tcr_state_e state;
	tcr_state_e next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic [TIMER_W-1:0] conv_last;
	logic [TIMER_W-1:0] period_last;
	logic [1:0] rate_sel;
	logic conv_end;
	logic next_adc_enable;
	logic next_shutdown_active;

	// result register, ref_clk side
	tcr_word_t result_word;
	tcr_word_t next_result_word;
	tcr_word_t formatted_word;
	logic result_toggle;
	logic next_result_toggle;

	// link side
	logic tog_meta;
	logic tog_sync;
	logic tog_seen;
	logic next_tog_meta;
	logic next_tog_sync;
	logic next_tog_seen;
	tcr_word_t link_word;
	tcr_word_t next_link_word;
	logic [7:0] next_rd_data;
	logic next_rd_valid;

	assign cfg_reset_value = '{rate_select_hi: RATE_RESET[1],
		rate_select_lo: RATE_RESET[0],
		extended_range_enable: 1'b0,
		power_down_request: 1'b0};

	// two-stage synchronisers for the configuration and converter code
	always_comb begin
		next_cfg_meta = cfg_meta;
		next_cfg_sync = cfg_sync;
		next_code_meta = code_meta;
		next_code_sync = code_sync;
		next_code_prev = code_prev;
		next_code_steady = code_steady;
		if (clk_en) begin
			next_cfg_meta = cfg;
			next_cfg_sync = cfg_meta;
			next_code_meta = adc_code;
			next_code_sync = code_meta;
			next_code_prev = code_sync;
			// a code caught while changing may mix old and new bits: take it once two samples agree
			if (code_sync == code_prev) begin
				next_code_steady = code_sync;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_meta <= cfg_reset_value;
			cfg_sync <= cfg_reset_value;
			code_meta <= `TCR_RESULT_RESET;
			code_sync <= `TCR_RESULT_RESET;
			code_prev <= `TCR_RESULT_RESET;
			code_steady <= `TCR_RESULT_RESET;
		end else begin
			cfg_meta <= next_cfg_meta;
			cfg_sync <= next_cfg_sync;
			code_meta <= next_code_meta;
			code_sync <= next_code_sync;
			code_prev <= next_code_prev;
			code_steady <= next_code_steady;
		end
	end

	// conversion interval for the selected rate, measured start to start
	assign rate_sel = {cfg_sync.rate_select_hi, cfg_sync.rate_select_lo};
	assign conv_last = TIMER_W'(CONV_CYCLES - 1);

	always_comb begin
		case (rate_sel)
			`TCR_RATE_025HZ: period_last = TIMER_W'(PERIOD_CYCLES_0 - 1);
			`TCR_RATE_1HZ: period_last = TIMER_W'(PERIOD_CYCLES_1 - 1);
			`TCR_RATE_4HZ: period_last = TIMER_W'(PERIOD_CYCLES_2 - 1);
			`TCR_RATE_8HZ: period_last = TIMER_W'(PERIOD_CYCLES_3 - 1);
			default: period_last = TIMER_W'(PERIOD_CYCLES_2 - 1);
		endcase
	end

	// >= so that a timer beyond the end still stops the conversion
	assign conv_end = (state == TCR_CONV) && (timer >= conv_last);

	// sequencer: convert, power down and wait, or sit in shutdown
	always_comb begin
		next_state = state;
		next_timer = timer;
		if (clk_en) begin
			case (state)
				TCR_CONV: begin
					if (conv_end) begin
						next_timer = timer + TIMER_W'(1);
						if (cfg_sync.power_down_request) begin
							next_state = TCR_SHUT;
							next_timer = '0;
						end else begin
							next_state = TCR_WAIT;
						end
					end else begin
						next_timer = timer + TIMER_W'(1);
					end
				end
				TCR_WAIT: begin
					if (cfg_sync.power_down_request) begin
						next_state = TCR_SHUT;
						next_timer = '0;
					// a rate picked mid-wait applies at once; a timer already past it ends the wait
					end else if (timer >= period_last) begin
						next_state = TCR_CONV;
						next_timer = '0;
					end else begin
						next_timer = timer + TIMER_W'(1);
					end
				end
				TCR_SHUT: begin
					// timer held at zero so a wake-up always begins a full conversion
					next_timer = '0;
					if (!cfg_sync.power_down_request) begin
						next_state = TCR_CONV;
					end
				end
				default: begin
					next_state = TCR_CONV;
					next_timer = '0;
				end
			endcase
		end
		// outputs are registered copies of the next state, free of decode glitches
		next_adc_enable = (next_state == TCR_CONV);
		next_shutdown_active = (next_state == TCR_SHUT);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= TCR_CONV;
			timer <= '0;
			adc_enable <= 1'b1;
			shutdown_active <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			adc_enable <= next_adc_enable;
			shutdown_active <= next_shutdown_active;
		end
	end

	// format the synchronised converter code with the mode in force now
	tcr_format u_format (
		.raw_code(code_steady),
		.extended_mode(cfg_sync.extended_range_enable),
		.result_word(formatted_word)
	);

	// result register: overwritten at each conversion end, event toggled across
	always_comb begin
		next_result_word = result_word;
		next_result_toggle = result_toggle;
		if (clk_en && conv_end) begin
			next_result_word = formatted_word;
			next_result_toggle = ~result_toggle;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			result_word <= `TCR_RESULT_RESET;
			result_toggle <= 1'b0;
		end else begin
			result_word <= next_result_word;
			result_toggle <= next_result_toggle;
		end
	end

	// link side: catch the toggle, copy the word that is held stable behind it
	always_comb begin
		next_tog_meta = result_toggle;
		next_tog_sync = tog_meta;
		next_tog_seen = tog_sync;
		next_link_word = link_word;
		// the word itself is not synchronised: it stands still a whole conversion after each toggle
		if (tog_sync != tog_seen) begin
			next_link_word = result_word;
		end
	end

	// byte reads: either byte alone, high byte needs no low byte after it
	always_comb begin
		next_rd_data = rd_data;
		next_rd_valid = 1'b0;
		if (rd_req) begin
			next_rd_valid = 1'b1;
			if (rd_byte_low) begin
				next_rd_data = link_word[`TCR_LO_BYTE];
			end else begin
				next_rd_data = link_word[`TCR_HI_BYTE];
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_reset) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
			link_word <= `TCR_RESULT_RESET;
		end else begin
			tog_meta <= next_tog_meta;
			tog_sync <= next_tog_sync;
			tog_seen <= next_tog_seen;
			link_word <= next_link_word;
		end
	end

	// rd_data keeps the last byte between reads
	always_ff @(posedge link_clk) begin
		if (link_reset) begin
			rd_data <= `TCR_BYTE_RESET;
			rd_valid <= 1'b0;
		end else begin
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

endmodule

`default_nettype wire
